// *** hdl/lpc_defs.svh ***
// Register offsets, field positions, reset values and codes
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

`define LPC_OFS_PCC0 8'h00
`define LPC_OFS_PCC1 8'h04
`define LPC_OFS_PCC3 8'h08
`define LPC_OFS_TMRSEL 8'h0c
`define LPC_OFS_LSPRE 8'h10
`define LPC_OFS_ACLK 8'h14
`define LPC_OFS_STAT 8'h18
`define LPC_OFS_HSHK 8'h1c
`define LPC_OFS_NMI 8'h20
`define LPC_OFS_WAKE 8'h24

`define LPC_LPM_MSB 1
`define LPC_LPM_LSB 0
`define LPC_QUAL_MSB 7
`define LPC_QUAL_LSB 2
`define LPC_GATE0_MSB 31
`define LPC_GATE0_LSB 8
`define LPC_TSRC_MSB 1
`define LPC_TSRC_LSB 0
`define LPC_TDIV_MSB 9
`define LPC_TDIV_LSB 2
`define LPC_WSEL_MSB 5
`define LPC_WSEL_LSB 0
`define LPC_WIRQ_BIT 6
`define LPC_WD_DIS_BIT 0
`define LPC_NMI_CLR_BIT 1

`define LPC_LPM_IDLE 2'h0
`define LPC_LPM_STANDBY 2'h1
`define LPC_TSRC_PERIPH 2'h0
`define LPC_TSRC_OSC 2'h1
`define LPC_TSRC_BACKUP 2'h2

`define LPC_PCC0_RST 32'h0000_0000
`define LPC_PCC_RST 32'h0000_0000
`define LPC_TMRSEL_RST 32'h0000_0000
`define LPC_LSPRE_RST 8'h02
`define LPC_ACLK_RST 8'h00
`define LPC_WAKE_RST 32'h0000_0000

`endif

// *** hdl/lpc_pkg.sv ***
// Types shared by the clock and low-power manager
package lpc_pkg;
   typedef enum logic [1:0] {LPC_NORMAL, LPC_IDLE, LPC_STANDBY} lpc_mode_t;
endpackage : lpc_pkg

// *** hdl/lpc_tick_div.sv ***
// Tick divider: one output tick for every div+1 input ticks
module lpc_tick_div #(
   parameter int W = 8
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic run,
   input wire logic in_tick,
   input wire logic [W-1:0] div,
   output logic out_tick
);
   logic [W-1:0] cnt;

   always_ff @(posedge sys_clk)
   begin
      if (srst || !run)
      begin
         cnt <= '0;
         out_tick <= 1'b0;
      end
      else
      begin
         out_tick <= 1'b0;
         if (in_tick)
         begin
            if (cnt >= div)
            begin
               cnt <= '0;
               out_tick <= 1'b1;
            end
            else
               cnt <= cnt + 1'b1;
         end
      end
   end
endmodule : lpc_tick_div

// *** hdl/lpc_wake_qual.sv ***
// Wake pin qualifier: pin must stay high for period+2 samples
module lpc_wake_qual #(
   parameter int W = 6
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic arm,
   input wire logic pin,
   input wire logic [W-1:0] period,
   output logic qualified
);
   logic [W:0] cnt;

   always_ff @(posedge sys_clk)
   begin
      if (srst || !arm || !pin)
      begin
         cnt <= '0;
         qualified <= 1'b0;
      end
      else if ({1'b0, period} < cnt)
         qualified <= 1'b1;
      else
         cnt <= cnt + 1'b1;
   end
endmodule : lpc_wake_qual

// *** hdl/lpc_clock_mgr.sv ***
// Control-subsystem clock and low-power manager with AHB-Lite registers
//
// What this block does
// - Normal mode: core and peripheral clocks, both from control input clock.
// - Timer two alternate clock: divided peripheral, oscillator or backup.
// - Programmable prescaler makes the low-speed serial peripheral clock.
// - Peripheral clock gated per peripheral by control registers 0, 1, 3.
// - Idle instruction stops processor, raises idle status; field picks mode.
// - Idle: core clock off, peripheral clock keeps running.
// - Idle ends on any enabled interrupt or control nonmaskable interrupt.
// - Idle exit restores core clock, runs wake handler if enabled, resumes.
// - Standby: input, core and peripheral clocks all off.
// - Standby ends on selected wake pin of 64 or master IPC interrupt two.
// - Wake pin is qualified per bits 7 to 2 of control register zero.
// - Standby exit restores clocks, runs wake handler if enabled, resumes.
// - Master deep sleep kills input clock; wake comes from master side only.
// - Analog clock is system clock divided by the analog divider field plus one.
// - Analog clock register reset by analog reset built from system reset and two analog resets.
// - Analog clock stops while master is in deep sleep.
// - Shared clock: PLL or oscillator via system divider, backup on loss.
// - Only the main oscillator is watched for loss of clock.
// - Missing-clock detector advances on the internal backup clock.
// - On loss, clock fail goes to NMI blocks, PWM and system clock mux.
// - Fail raises NMI, starts watchdog; overflow resets unless disabled.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`include "lpc_defs.svh"
module lpc_clock_mgr
   import lpc_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int DIV_W = 8,
   parameter int MISS_TICKS = 8,
   parameter int NMI_WD_CYCLES = 65536
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic pll_tick,
   input wire logic osc_tick,
   input wire logic backup_tick,
   input wire logic pll_bypass,
   input wire logic [DIV_W-1:0] system_divider_select,
   input wire logic analog_iface_reset,
   input wire logic analog_sub_reset_two,
   input wire logic master_deep_sleep,
   input wire logic idle_instr,
   input wire logic enabled_irq,
   input wire logic [63:0] wake_pins,
   input wire logic master_to_ctrl_ipc_irq_two,
   output logic shared_system_clk,
   output logic ctrl_input_clk,
   output logic ctrl_core_clk,
   output logic ctrl_periph_clk,
   output logic low_speed_periph_clk,
   output logic timer_two_alt_clk,
   output logic analog_subsys_clk,
   output logic [23:0] periph_gate_zero,
   output logic [31:0] periph_gate_one,
   output logic [31:0] periph_gate_three,
   output logic idle_status_sig,
   output logic wake_isr_req,
   output logic cpu_resume,
   output logic clock_fail_sig,
   output logic ctrl_nonmaskable_irq,
   output logic nmi_wd_reset,
   output logic [7:0] lowpower_handshake_status
);
   localparam int MISS_W = $clog2(MISS_TICKS + 1);
   localparam int WD_W = $clog2(NMI_WD_CYCLES + 1);

   logic [31:0] periph_clk_ctrl_zero;
   logic [31:0] periph_clk_ctrl_one;
   logic [31:0] periph_clk_ctrl_three;
   logic [31:0] timer_clk_select_reg;
   logic [7:0] low_speed_prescaler;
   logic [7:0] analog_clk_ctrl_reg;
   logic [31:0] wake_cfg;
   logic wd_disable;
   logic ph_wr;
   logic [7:0] ph_addr;
   logic [31:0] rd_mux;
   lpc_mode_t mode;
   lpc_mode_t next_mode;
   logic [1:0] low_power_mode_field;
   logic leave_lp;
   logic standby_wake_sig;
   logic wake_qualified;
   logic sys_div_tick;
   logic ctrl_sys_tick;
   logic timer_src_tick;
   logic [MISS_W-1:0] miss_cnt;
   logic fail_set;
   logic [WD_W-1:0] wd_cnt;
   logic analog_subsys_reset;

   assign low_power_mode_field =
      periph_clk_ctrl_zero[`LPC_LPM_MSB:`LPC_LPM_LSB];

   // Register bus: zero wait state, always OKAY
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Address phase captured here, write completes in the data phase
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ph_wr <= 1'b0;
         ph_addr <= 8'h00;
      end
      else if (hready)
      begin
         ph_wr <= hsel && htrans[1] && hwrite;
         ph_addr <= haddr[7:0];
      end
   end

   // Upper address bits are not decoded, so the map aliases
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         `LPC_OFS_PCC0: rd_mux = periph_clk_ctrl_zero;
         `LPC_OFS_PCC1: rd_mux = periph_clk_ctrl_one;
         `LPC_OFS_PCC3: rd_mux = periph_clk_ctrl_three;
         `LPC_OFS_TMRSEL: rd_mux = timer_clk_select_reg;
         `LPC_OFS_LSPRE: rd_mux = {24'h00_0000, low_speed_prescaler};
         `LPC_OFS_ACLK: rd_mux = {24'h00_0000, analog_clk_ctrl_reg};
         `LPC_OFS_STAT: rd_mux = {26'h0, nmi_wd_reset,
            wd_disable, ctrl_nonmaskable_irq, clock_fail_sig, mode};
         `LPC_OFS_HSHK: rd_mux = {24'h00_0000, lowpower_handshake_status};
         `LPC_OFS_NMI: rd_mux = {31'h0, wd_disable};
         `LPC_OFS_WAKE: rd_mux = wake_cfg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         hrdata <= 32'h0000_0000;
      else if (hready && hsel && htrans[1] && !hwrite)
         hrdata <= rd_mux;
   end

   // Clock control registers written in the data phase
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         periph_clk_ctrl_zero <= `LPC_PCC0_RST;
         periph_clk_ctrl_one <= `LPC_PCC_RST;
         periph_clk_ctrl_three <= `LPC_PCC_RST;
         timer_clk_select_reg <= `LPC_TMRSEL_RST;
         low_speed_prescaler <= `LPC_LSPRE_RST;
         wake_cfg <= `LPC_WAKE_RST;
         lowpower_handshake_status <= 8'h00;
      end
      else if (ph_wr)
      begin
         unique case (ph_addr)
            `LPC_OFS_PCC0: periph_clk_ctrl_zero <= hwdata;
            `LPC_OFS_PCC1: periph_clk_ctrl_one <= hwdata;
            `LPC_OFS_PCC3: periph_clk_ctrl_three <= hwdata;
            `LPC_OFS_TMRSEL: timer_clk_select_reg <= hwdata;
            `LPC_OFS_LSPRE: low_speed_prescaler <= hwdata[7:0];
            `LPC_OFS_WAKE: wake_cfg <= hwdata;
            // Control software posts its standby intent for the master
            `LPC_OFS_HSHK: lowpower_handshake_status <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Own reset lets the master restore the analog divider default
   assign analog_subsys_reset =
      srst || analog_iface_reset || analog_sub_reset_two;

   always_ff @(posedge sys_clk)
   begin
      if (analog_subsys_reset)
         analog_clk_ctrl_reg <= `LPC_ACLK_RST;
      else if (ph_wr && ph_addr == `LPC_OFS_ACLK)
         analog_clk_ctrl_reg <= hwdata[7:0];
   end

   // Low-power mode sequencing
   assign standby_wake_sig = wake_pins[wake_cfg[`LPC_WSEL_MSB:`LPC_WSEL_LSB]];

   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         LPC_NORMAL:
            if (idle_instr)
            begin
               if (low_power_mode_field == `LPC_LPM_STANDBY)
                  next_mode = LPC_STANDBY;
               else
                  next_mode = LPC_IDLE;
            end
         LPC_IDLE:
            if (enabled_irq || ctrl_nonmaskable_irq || fail_set)
               next_mode = LPC_NORMAL;
         LPC_STANDBY:
            // Pin wake cannot act while the master sleeps: no clocks here
            if ((wake_qualified && !master_deep_sleep) ||
               master_to_ctrl_ipc_irq_two)
               next_mode = LPC_NORMAL;
      endcase
   end

   assign leave_lp = (mode != LPC_NORMAL) && (next_mode == LPC_NORMAL);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         mode <= LPC_NORMAL;
         idle_status_sig <= 1'b0;
         wake_isr_req <= 1'b0;
         cpu_resume <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         idle_status_sig <= next_mode != LPC_NORMAL;
         wake_isr_req <= leave_lp && wake_cfg[`LPC_WIRQ_BIT];
         cpu_resume <= leave_lp;
      end
   end

   lpc_wake_qual #(
      .W(`LPC_QUAL_MSB - `LPC_QUAL_LSB + 1)
   ) u_qual (
      .sys_clk(sys_clk),
      .srst(srst),
      .arm(mode == LPC_STANDBY),
      .pin(standby_wake_sig),
      .period(periph_clk_ctrl_zero[`LPC_QUAL_MSB:`LPC_QUAL_LSB]),
      .qualified(wake_qualified)
   );

   // Missing-clock detector: counts backup ticks between oscillator ticks
   // The secondary external clock is deliberately not watched
   assign fail_set = !clock_fail_sig && !osc_tick && backup_tick &&
      miss_cnt == MISS_W'(MISS_TICKS - 1);

   always_ff @(posedge sys_clk)
   begin
      if (srst || osc_tick)
         miss_cnt <= '0;
      else if (backup_tick && !clock_fail_sig)
         miss_cnt <= miss_cnt + 1'b1;
   end

   // Fail is sticky until reset; software recovery goes through a reset
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         clock_fail_sig <= 1'b0;
         ctrl_nonmaskable_irq <= 1'b0;
      end
      else
      begin
         if (fail_set)
            clock_fail_sig <= 1'b1;
         if (fail_set)
            ctrl_nonmaskable_irq <= 1'b1;
         else if (ph_wr && ph_addr == `LPC_OFS_NMI &&
            hwdata[`LPC_NMI_CLR_BIT])
            ctrl_nonmaskable_irq <= 1'b0;
      end
   end

   // NMI watchdog; disable is write-one-only so it cannot be re-armed
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wd_disable <= 1'b0;
         wd_cnt <= '0;
         nmi_wd_reset <= 1'b0;
      end
      else
      begin
         if (ph_wr && ph_addr == `LPC_OFS_NMI && hwdata[`LPC_WD_DIS_BIT])
            wd_disable <= 1'b1;
         if (clock_fail_sig && !wd_disable && !nmi_wd_reset)
         begin
            if (wd_cnt == WD_W'(NMI_WD_CYCLES - 1))
               nmi_wd_reset <= 1'b1;
            else
               wd_cnt <= wd_cnt + 1'b1;
         end
      end
   end

   // Shared system clock path
   lpc_tick_div #(
      .W(DIV_W)
   ) u_sysdiv (
      .sys_clk(sys_clk),
      .srst(srst),
      .run(1'b1),
      .in_tick(pll_bypass ? osc_tick : pll_tick),
      .div(system_divider_select),
      .out_tick(sys_div_tick)
   );

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         shared_system_clk <= 1'b0;
      else if (clock_fail_sig)
         shared_system_clk <= backup_tick;
      else
         shared_system_clk <= sys_div_tick;
   end

   // Control-side clocks follow the mode the processor is entering
   assign ctrl_sys_tick = shared_system_clk && !master_deep_sleep;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ctrl_input_clk <= 1'b0;
         ctrl_periph_clk <= 1'b0;
         ctrl_core_clk <= 1'b0;
      end
      else
      begin
         ctrl_input_clk <= ctrl_sys_tick &&
            next_mode != LPC_STANDBY;
         ctrl_periph_clk <= ctrl_sys_tick &&
            next_mode != LPC_STANDBY;
         ctrl_core_clk <= ctrl_sys_tick &&
            next_mode == LPC_NORMAL;
      end
   end

   // Per-peripheral gates on the peripheral clock
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         periph_gate_zero <= '0;
         periph_gate_one <= '0;
         periph_gate_three <= '0;
      end
      else
      begin
         periph_gate_zero <= {24{ctrl_periph_clk}} &
            periph_clk_ctrl_zero[`LPC_GATE0_MSB:`LPC_GATE0_LSB];
         periph_gate_one <= {32{ctrl_periph_clk}} &
            periph_clk_ctrl_one;
         periph_gate_three <= {32{ctrl_periph_clk}} &
            periph_clk_ctrl_three;
      end
   end

   always_comb
   begin
      unique case (timer_clk_select_reg[`LPC_TSRC_MSB:`LPC_TSRC_LSB])
         `LPC_TSRC_PERIPH: timer_src_tick = ctrl_periph_clk;
         `LPC_TSRC_OSC: timer_src_tick = osc_tick;
         `LPC_TSRC_BACKUP: timer_src_tick = backup_tick;
         default: timer_src_tick = 1'b0;
      endcase
   end

   lpc_tick_div #(
      .W(`LPC_TDIV_MSB - `LPC_TDIV_LSB + 1)
   ) u_tmrdiv (
      .sys_clk(sys_clk),
      .srst(srst),
      .run(1'b1),
      .in_tick(timer_src_tick),
      .div(timer_clk_select_reg[`LPC_TDIV_MSB:`LPC_TDIV_LSB]),
      .out_tick(timer_two_alt_clk)
   );

   lpc_tick_div #(
      .W(8)
   ) u_lspdiv (
      .sys_clk(sys_clk),
      .srst(srst),
      .run(1'b1),
      .in_tick(ctrl_periph_clk),
      .div(low_speed_prescaler),
      .out_tick(low_speed_periph_clk)
   );

   lpc_tick_div #(
      .W(8)
   ) u_adiv (
      .sys_clk(sys_clk),
      .srst(analog_subsys_reset),
      .run(!master_deep_sleep),
      .in_tick(shared_system_clk),
      .div(analog_clk_ctrl_reg),
      .out_tick(analog_subsys_clk)
   );

   chk_idle_entry: assert property (@(posedge sys_clk) disable iff (srst)
      mode == LPC_NORMAL && idle_instr &&
      low_power_mode_field != `LPC_LPM_STANDBY
      |=> mode == LPC_IDLE && idle_status_sig)
      else $error("idle entry missed");
   chk_core_off_idle: assert property (@(posedge sys_clk) disable iff (srst)
      mode == LPC_IDLE |-> !ctrl_core_clk)
      else $error("core clock running in idle");
   chk_standby_clocks: assert property (@(posedge sys_clk)
      disable iff (srst)
      mode == LPC_STANDBY |-> !ctrl_input_clk && !ctrl_periph_clk &&
      !ctrl_core_clk)
      else $error("clock running in standby");
   chk_idle_exit: assert property (@(posedge sys_clk) disable iff (srst)
      mode == LPC_IDLE && enabled_irq |=> mode == LPC_NORMAL &&
      cpu_resume)
      else $error("idle exit missed");
   chk_ipc_wake: assert property (@(posedge sys_clk) disable iff (srst)
      mode == LPC_STANDBY && master_to_ctrl_ipc_irq_two
      |=> mode == LPC_NORMAL && cpu_resume ##1 !cpu_resume)
      else $error("standby wake missed");
   chk_fail_nmi: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(clock_fail_sig) |-> ctrl_nonmaskable_irq)
      else $error("no nmi on clock fail");
   chk_backup_switch: assert property (@(posedge sys_clk)
      disable iff (srst)
      clock_fail_sig |=> shared_system_clk == $past(backup_tick))
      else $error("system clock not on backup");
   chk_analog_stop: assert property (@(posedge sys_clk) disable iff (srst)
      master_deep_sleep |=> !analog_subsys_clk && !ctrl_input_clk)
      else $error("clock alive in deep sleep");
   chk_osc_alive: assert property (@(posedge sys_clk) disable iff (srst)
      osc_tick |=> !$rose(clock_fail_sig))
      else $error("fail flagged with oscillator alive");
endmodule : lpc_clock_mgr

// *** tb/lpc_master_model.sv ***
// Behavioural master side: source ticks, deep sleep and IPC wake
module lpc_master_model
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic osc_stop,
   input wire logic sleep_req,
   input wire logic ipc_req,
   input wire logic [7:0] lowpower_handshake_status,
   output logic pll_tick = 1'b0,
   output logic osc_tick = 1'b0,
   output logic backup_tick = 1'b0,
   output logic master_deep_sleep = 1'b0,
   output logic master_to_ctrl_ipc_irq_two = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned ph = 0;

   // Unrelated rates so that a wrong source shows up in the counts
   always_ff @(posedge sys_clk)
   begin
      ph <= ph + 1;
      pll_tick <= (ph % 2 == 0);
      osc_tick <= (ph % 3 == 0) && !osc_stop;
      backup_tick <= (ph % 5 == 0);
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         master_deep_sleep <= 1'b0;
         master_to_ctrl_ipc_irq_two <= 1'b0;
      end
      else
      begin
         master_to_ctrl_ipc_irq_two <= ipc_req;
         if (ipc_req)
            master_deep_sleep <= 1'b0;
         // Sleeps only once the control side has announced standby
         else if (sleep_req && lowpower_handshake_status == 8'h01)
            master_deep_sleep <= 1'b1;
      end
   end
endmodule : lpc_master_model

// *** tb/tb_ctrl_subsys_lowpower_clock_mgr.sv ***
// Self-checking bench for the clock and low-power manager
module tb_ctrl_subsys_lowpower_clock_mgr;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, srst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic [11:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = '0, hrdata;
   logic pll_tick, osc_tick, backup_tick, deep, ipc_irq;
   logic a_rst = 0, b_rst = 0, idle_instr = 0, enabled_irq = 0;
   logic osc_stop = 0, sleep_req = 0, ipc_req = 0, bypass = 0;
   logic [7:0] sdiv = '0;
   logic [63:0] wake_pins = '0;
   logic [6:0] clks;
   logic [3:0] ev;
   logic [23:0] g0;
   logic [31:0] g1, g3;
   logic idle_st, isr, resume, fail, nmi, wd_rst;
   logic [7:0] hshk;
   int n_fail = 0, n_tests = 0;
   int c[7];

   lpc_clock_mgr #(.MISS_TICKS(3), .NMI_WD_CYCLES(16)) dut_u (
      .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .pll_tick(pll_tick), .osc_tick(osc_tick),
      .backup_tick(backup_tick), .pll_bypass(bypass),
      .system_divider_select(sdiv), .analog_iface_reset(a_rst),
      .analog_sub_reset_two(b_rst), .master_deep_sleep(deep),
      .idle_instr(idle_instr), .enabled_irq(enabled_irq),
      .wake_pins(wake_pins), .master_to_ctrl_ipc_irq_two(ipc_irq),
      .shared_system_clk(clks[0]), .ctrl_input_clk(clks[1]),
      .ctrl_core_clk(clks[2]), .ctrl_periph_clk(clks[3]),
      .low_speed_periph_clk(clks[4]), .timer_two_alt_clk(clks[5]),
      .analog_subsys_clk(clks[6]), .periph_gate_zero(g0),
      .periph_gate_one(g1), .periph_gate_three(g3),
      .idle_status_sig(idle_st), .wake_isr_req(isr), .cpu_resume(resume),
      .clock_fail_sig(fail), .ctrl_nonmaskable_irq(nmi),
      .nmi_wd_reset(wd_rst), .lowpower_handshake_status(hshk));

   lpc_master_model master_u (
      .sys_clk(sys_clk), .srst(srst), .osc_stop(osc_stop),
      .sleep_req(sleep_req), .ipc_req(ipc_req),
      .lowpower_handshake_status(hshk), .pll_tick(pll_tick),
      .osc_tick(osc_tick), .backup_tick(backup_tick),
      .master_deep_sleep(deep), .master_to_ctrl_ipc_irq_two(ipc_irq));

   assign ev = {wd_rst, fail, resume, deep};

   initial
   begin
      sys_clk = 0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      if (got !== exp)
         n_fail++;
   endtask : chk

   // Pulse counts drift by the phase of the divider, hence the slack
   task automatic chk_n(input int got, input int exp);
      n_tests++;
      if (got > exp + 2 || got < exp - 2)
      begin
         n_fail++;
         $display("FAIL %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_n

   task automatic wait_rdy;
      int k;
      k = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1 && k < 50)
      begin
         @(posedge sys_clk);
         k++;
      end
   endtask : wait_rdy

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {4'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask : rd

   task automatic count(input int n);
      c = '{default: 0};
      repeat (n)
      begin
         @(posedge sys_clk);
         #1;
         for (int i = 0; i < 7; i++)
            c[i] += int'(clks[i] === 1'b1);
      end
   endtask : count

   task automatic wait_ev(input int i, input int lim);
      int k;
      k = 0;
      do
      begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      while (ev[i] !== 1'b1 && k < lim);
      chk(ev[i], 1'b1);
   endtask : wait_ev

   task automatic go_idle;
      @(posedge sys_clk);
      idle_instr <= 1'b1;
      @(posedge sys_clk);
      idle_instr <= 1'b0;
      #1;
      chk(idle_st, 1'b1);
   endtask : go_idle

   task automatic s_regs;
      rd(8'h10, 32'h2);
      rd(8'h14, 32'h0);
      rd(8'h00, 32'h0);
      rd(8'h18, 32'h0);
      rd(8'h3c, 32'h0);
      chk(hresp, 1'b0);
   endtask : s_regs

   task automatic s_clocks;
      logic [31:0] tsel[3] = '{32'h5, 32'h2, 32'h8};
      int texp[3] = '{50, 60, 50};
      wr(8'h14, 32'h3);
      count(600);
      chk_n(c[0], 300);
      chk_n(c[1], 300);
      chk_n(c[2], 300);
      chk_n(c[3], 300);
      chk_n(c[4], 100);
      chk_n(c[6], 75);
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h0c, tsel[i]);
         count(300);
         chk_n(c[5], texp[i]);
      end
      @(posedge sys_clk);
      bypass <= 1'b1;
      sdiv <= 8'h01;
      count(300);
      chk_n(c[0], 50);
      @(posedge sys_clk);
      bypass <= 1'b0;
      sdiv <= 8'h00;
   endtask : s_clocks

   task automatic s_gate;
      logic p;
      wr(8'h04, 32'h5);
      wr(8'h08, 32'h8000_0000);
      wr(8'h00, 32'h100);
      #1;
      p = clks[3];
      repeat (30)
      begin
         @(posedge sys_clk);
         #1;
         chk(g1, p ? 32'h5 : 32'h0);
         chk(g3, p ? 32'h8000_0000 : 32'h0);
         chk({8'h0, g0}, p ? 32'h1 : 32'h0);
         p = clks[3];
      end
   endtask : s_gate

   task automatic s_idle;
      logic [1:0] codes[3] = '{2'h0, 2'h2, 2'h3};
      wr(8'h24, 32'h40);
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h00, {30'h0, codes[i]});
         go_idle();
         count(20);
         chk_n(c[2], 0);
         chk_n(c[3], 10);
         rd(8'h18, 32'h1);
         @(posedge sys_clk);
         enabled_irq <= 1'b1;
         @(posedge sys_clk);
         enabled_irq <= 1'b0;
         #1;
         chk({idle_st, resume, isr}, 3'b011);
      end
   endtask : s_idle

   task automatic s_standby;
      wr(8'h24, 32'h7f);
      wr(8'h00, 32'h9);
      wr(8'h1c, 32'h1);
      go_idle();
      count(20);
      chk_n(c[1] + c[2] + c[3], 0);
      @(posedge sys_clk);
      wake_pins <= 64'h8000_0000_0000_0000;
      repeat (3) @(posedge sys_clk);
      wake_pins <= '0;
      repeat (6) @(posedge sys_clk);
      chk(idle_st, 1'b1);
      wake_pins <= 64'h8000_0000_0000_0000;
      wait_ev(1, 12);
      chk({idle_st, isr}, 2'b01);
      @(posedge sys_clk);
      wake_pins <= '0;
      go_idle();
      @(posedge sys_clk);
      sleep_req <= 1'b1;
      wake_pins <= 64'h8000_0000_0000_0000;
      wait_ev(0, 10);
      count(30);
      chk_n(c[1] + c[6], 0);
      chk(idle_st, 1'b1);
      @(posedge sys_clk);
      sleep_req <= 1'b0;
      wake_pins <= '0;
      ipc_req <= 1'b1;
      @(posedge sys_clk);
      ipc_req <= 1'b0;
      wait_ev(1, 8);
      count(20);
      chk_n(c[1], 10);
      chk_n(c[2], 10);
   endtask : s_standby

   task automatic s_areset;
      wr(8'h14, 32'h5);
      @(posedge sys_clk);
      a_rst <= 1'b1;
      @(posedge sys_clk);
      a_rst <= 1'b0;
      rd(8'h14, 32'h0);
      wr(8'h14, 32'h5);
      @(posedge sys_clk);
      b_rst <= 1'b1;
      @(posedge sys_clk);
      b_rst <= 1'b0;
      rd(8'h14, 32'h0);
   endtask : s_areset

   task automatic s_fail;
      @(posedge sys_clk);
      osc_stop <= 1'b1;
      wait_ev(2, 60);
      chk(nmi, 1'b1);
      wait_ev(3, 30);
      count(600);
      chk_n(c[0], 120);
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      wait_ev(2, 60);
      wr(8'h20, 32'h3);
      repeat (40) @(posedge sys_clk);
      #1;
      chk({wd_rst, nmi}, 2'b00);
   endtask : s_fail

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   initial
   begin
      #60000;
      n_fail++;
      $display("FAIL %0t watchdog expired", $time);
      print_verdict();
   end

   initial
   begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      s_regs();
      s_clocks();
      s_gate();
      s_idle();
      s_standby();
      s_areset();
      s_fail();
      print_verdict();
   end
endmodule : tb_ctrl_subsys_lowpower_clock_mgr
